// >>> logic/dpg_gpio.sv
// Dual 8-bit GPIO port with AXI4-Lite register access
module dpg_gpio #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite write address
    input  wire logic [dpg_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [dpg_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Port A pins
    input  wire logic [WIDTH-1:0]            porta_pin_in,
    output logic [WIDTH-1:0]                 porta_pin_out,
    output logic [WIDTH-1:0]                 porta_pin_oe,
    output logic [WIDTH-1:0]                 porta_pullup_on,
    output logic [WIDTH-1:0]                 porta_pulldown_on,
    // Port B pins
    input  wire logic [WIDTH-1:0]            portb_pin_in,
    output logic [WIDTH-1:0]                 portb_pin_out,
    output logic [WIDTH-1:0]                 portb_pin_oe,
    output logic [WIDTH-1:0]                 portb_pullup_on,
    output logic [WIDTH-1:0]                 portb_pulldown_on,
    // Gated port B levels for wake-up and interrupt logic elsewhere
    output logic [WIDTH-1:0]                 portb_event_level
);

    // Software registers
    // Byte-wide; only lane 0 of the bus reaches them
    logic [WIDTH-1:0] porta_data_latch;      // Port A output latch
    logic [WIDTH-1:0] porta_direction;       // Port A direction
    logic [WIDTH-1:0] porta_pullup_enable;   // Port A pull-up enables
    logic [WIDTH-1:0] porta_pulldown_enable; // Port A pull-down enables
    logic [WIDTH-1:0] portb_data_latch;      // Port B output latch
    logic [WIDTH-1:0] portb_direction;       // Port B direction
    logic [WIDTH-1:0] portb_pullup_enable;   // Port B pull-up enables
    logic [WIDTH-1:0] portb_pulldown_enable; // Port B pull-down enables
    logic [WIDTH-1:0] portb_input_enable;    // Port B digital input enables

    // Pin synchronisers
    logic [WIDTH-1:0] pa_meta;               // First stage, port A
    logic [WIDTH-1:0] pa_sync;               // Second stage, port A
    logic [WIDTH-1:0] pb_meta;               // First stage, port B
    logic [WIDTH-1:0] pb_sync;               // Second stage, port B

    // Write channel holding state
    // Address and data may arrive in either order; each waits here
    logic                      aw_held;      // Write address captured
    logic [dpg_pkg::ADDR_W-1:0] aw_addr;     // Captured write address
    logic                      w_held;       // Write data captured
    logic [31:0]               w_data;       // Captured write data
    logic                      w_strb0;      // Captured low byte strobe

    // Two-stage synchroniser on every pin input
    // Only the second stage feeds logic; the first may be metastable
    always_ff @(posedge aclk) begin
        // Both stages clear so reads start from a known low
        if (!aresetn) begin
            pa_meta <= '0;
            pa_sync <= '0;
            pb_meta <= '0;
            pb_sync <= '0;
        end else begin
            // Pins are asynchronous to aclk
            pa_meta <= porta_pin_in;
            pa_sync <= pa_meta;
            // Port B levels are gated later, after the second stage
            pb_meta <= portb_pin_in;
            pb_sync <= pb_meta;
        end
    end

    // Gated pin levels per bit
    // Port A has no input enable here; its input pins always read the pin level
    wire [WIDTH-1:0] porta_read_val;         // Port A value seen by reads
    wire [WIDTH-1:0] portb_gated;            // Port B level after input enable
    wire [WIDTH-1:0] portb_read_val;         // Port B value seen by reads
    wire [WIDTH-1:0] next_pa_pu;             // Port A pull-up after mode gate
    wire [WIDTH-1:0] next_pb_pu;             // Port B pull-up after mode gate

    // One slice per pin; port B adds the input-enable gate that port A lacks
    // A cleared input enable forces the gated level low
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            // Disabled input reads as constant low
            assign portb_gated[gi]    = portb_input_enable[gi] & pb_sync[gi];
            // Output pins read the latch, inputs the pin
            assign porta_read_val[gi] = porta_direction[gi] ? porta_data_latch[gi]
                                                            : pa_sync[gi];
            assign portb_read_val[gi] = portb_direction[gi] ? portb_data_latch[gi]
                                                            : portb_gated[gi];
            // Pull-up only while the pin is an input
            assign next_pa_pu[gi]     = porta_pullup_enable[gi] & ~porta_direction[gi];
            assign next_pb_pu[gi]     = portb_pullup_enable[gi] & ~portb_direction[gi];
        end
    endgenerate

    // Pin drivers, all registered
    // Flops keep decode glitches away from the pads
    always_ff @(posedge aclk) begin
        // All pins released: inputs, no pulls
        if (!aresetn) begin
            porta_pin_out     <= '0;
            porta_pin_oe      <= '0;
            porta_pullup_on   <= '0;
            porta_pulldown_on <= '0;
            portb_pin_out     <= '0;
            portb_pin_oe      <= '0;
            portb_pullup_on   <= '0;
            portb_pulldown_on <= '0;
            portb_event_level <= '0;
        end else begin
            // One cycle behind the software registers
            porta_pin_out     <= porta_data_latch;
            porta_pin_oe      <= porta_direction;
            porta_pullup_on   <= next_pa_pu;
            porta_pulldown_on <= porta_pulldown_enable;
            // Port B mirrors port A, plus the gated event level
            portb_pin_out     <= portb_data_latch;
            portb_pin_oe      <= portb_direction;
            portb_pullup_on   <= next_pb_pu;
            portb_pulldown_on <= portb_pulldown_enable;
            portb_event_level <= portb_gated;
        end
    end

    // Write decode
    // A write commits only when both halves are held and the previous
    // response has been taken, so one write is in flight at a time
    wire                 wr_fire   = aw_held && w_held && !s_axi_bvalid; // Both halves present
    wire [7:0]           wr_idx    = 8'(aw_addr >> 2);                  // Register index
    wire                 wr_align  = (aw_addr[1:0] == 2'h0);           // Word aligned
    wire                 wr_en     = wr_fire && w_strb0;               // Low lane written
    wire [WIDTH-1:0]     wr_byte   = w_data[WIDTH-1:0];                // Byte to store
    // Mapped registers; anything else answers with an error
    wire                 wr_hit    = wr_align && (wr_idx == dpg_pkg::IDX_PB_IEN  ||
                                     wr_idx == dpg_pkg::IDX_PA_DATA ||
                                     wr_idx == dpg_pkg::IDX_PA_DIR  ||
                                     wr_idx == dpg_pkg::IDX_PA_PU   ||
                                     wr_idx == dpg_pkg::IDX_PA_PD   ||
                                     wr_idx == dpg_pkg::IDX_PB_DATA ||
                                     wr_idx == dpg_pkg::IDX_PB_DIR  ||
                                     wr_idx == dpg_pkg::IDX_PB_PU   ||
                                     wr_idx == dpg_pkg::IDX_PB_PD);

    // Write address and data capture, independent order
    always_ff @(posedge aclk) begin
        // Both slots empty after reset
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held  <= 1'b0;
            w_data  <= '0;
            w_strb0 <= 1'b0;
        end else begin
            // Address slot: filled on its handshake, freed on commit
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            // Data slot: same, independent of the address slot
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                w_data  <= s_axi_wdata;
                w_strb0 <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held  <= 1'b0;
            end
        end
    end

    // Ready while the holding slot is free
    // Ready drops the cycle after a handshake, so a held slot is never
    // overwritten before its commit
    always_ff @(posedge aclk) begin
        // Not ready during reset; rises one cycle after release
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // Write response
    // Commit wins over bready, so a new answer is never lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dpg_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            // Unmapped or unaligned address answers with an error
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? dpg_pkg::RESP_OKAY : dpg_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            // Answer taken
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register file writes
    // Input enables start set, everything else clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            portb_input_enable    <= dpg_pkg::RST_PB_IEN;
            porta_data_latch      <= dpg_pkg::RST_ZERO;
            porta_direction       <= dpg_pkg::RST_ZERO;
            porta_pullup_enable   <= dpg_pkg::RST_ZERO;
            porta_pulldown_enable <= dpg_pkg::RST_ZERO;
            portb_data_latch      <= dpg_pkg::RST_ZERO;
            portb_direction       <= dpg_pkg::RST_ZERO;
            portb_pullup_enable   <= dpg_pkg::RST_ZERO;
            portb_pulldown_enable <= dpg_pkg::RST_ZERO;
        end else if (wr_en && wr_align) begin
            // Low byte lane and an aligned address are both needed
            unique case (wr_idx)
                dpg_pkg::IDX_PB_IEN:  portb_input_enable    <= wr_byte;
                dpg_pkg::IDX_PA_DATA: porta_data_latch      <= wr_byte;
                dpg_pkg::IDX_PA_DIR:  porta_direction       <= wr_byte;
                dpg_pkg::IDX_PA_PU:   porta_pullup_enable   <= wr_byte;
                dpg_pkg::IDX_PA_PD:   porta_pulldown_enable <= wr_byte;
                dpg_pkg::IDX_PB_DATA: portb_data_latch      <= wr_byte;
                dpg_pkg::IDX_PB_DIR:  portb_direction       <= wr_byte;
                dpg_pkg::IDX_PB_PU:   portb_pullup_enable   <= wr_byte;
                dpg_pkg::IDX_PB_PD:   portb_pulldown_enable <= wr_byte;
                default: ;
            endcase
        end
    end

    // Read decode
    // Decoded off the live address, which stands while arvalid is high
    wire [7:0]       rd_idx   = 8'(s_axi_araddr >> 2);          // Register index
    wire             rd_align = (s_axi_araddr[1:0] == 2'h0);   // Word aligned
    logic [WIDTH-1:0] rd_byte;                                 // Selected value
    logic             rd_hit;                                  // Readable register

    // Read multiplexer; enable register is write-only
    // Unmapped indices read zero and answer with an error
    always_comb begin
        // Defaults: zero data, hit decided by alignment
        rd_byte = '0;
        rd_hit  = rd_align;
        unique case (rd_idx)
            dpg_pkg::IDX_PA_DATA: rd_byte = porta_read_val;
            dpg_pkg::IDX_PA_DIR:  rd_byte = porta_direction;
            dpg_pkg::IDX_PA_PU:   rd_byte = porta_pullup_enable;
            dpg_pkg::IDX_PA_PD:   rd_byte = porta_pulldown_enable;
            dpg_pkg::IDX_PB_DATA: rd_byte = portb_read_val;
            dpg_pkg::IDX_PB_DIR:  rd_byte = portb_direction;
            dpg_pkg::IDX_PB_PU:   rd_byte = portb_pullup_enable;
            dpg_pkg::IDX_PB_PD:   rd_byte = portb_pulldown_enable;
            dpg_pkg::IDX_PB_IEN:  rd_byte = '0;
            default:              rd_hit  = 1'b0;
        endcase
    end

    // Read channel: one outstanding read
    always_ff @(posedge aclk) begin
        // Ready low during reset; rises one cycle after release
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= dpg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            // Address taken: data and response captured at this edge
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {{(32-WIDTH){1'b0}}, rd_byte};
            s_axi_rresp   <= rd_hit ? dpg_pkg::RESP_OKAY : dpg_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            // Answer stands until rready
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            // Idle: offer the address channel again
            s_axi_arready <= 1'b1;
        end
    end

endmodule // dpg_gpio

// >>> logic/dpg_pkg.sv
// Constants and register map for the dual-port GPIO block
package dpg_pkg;
    // Printed offsets are register indices; byte address is index times four
    localparam logic [7:0] IDX_PB_IEN   = 8'h0E;
    localparam logic [7:0] IDX_PA_DATA  = 8'h10;
    localparam logic [7:0] IDX_PA_DIR   = 8'h11;
    localparam logic [7:0] IDX_PA_PU    = 8'h12;
    localparam logic [7:0] IDX_PA_PD    = 8'h13;
    localparam logic [7:0] IDX_PB_DATA  = 8'h15;
    localparam logic [7:0] IDX_PB_DIR   = 8'h16;
    localparam logic [7:0] IDX_PB_PU    = 8'h17;
    localparam logic [7:0] IDX_PB_PD    = 8'h18;
    // Reset values
    localparam logic [7:0] RST_PB_IEN   = 8'hFF;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    // AXI response codes
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    // Address width of the bus slave
    localparam int         ADDR_W       = 8;
endpackage : dpg_pkg

// >>> verification/dpg_board.sv
// Board model that resolves the level on one 8-pin port
module dpg_board (
    // Block pin controls
    input wire logic [7:0] out_lv,
    input wire logic [7:0] oe,
    input wire logic [7:0] pu,
    input wire logic [7:0] pd,
    // Board drive and its enables
    input wire logic [7:0] ext_lv,
    input wire logic [7:0] ext_en,
    // Level seen by the block
    output logic [7:0]     pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Block drive wins, then board, then pulls; a floating pin shows the inverse value
    assign pin = (oe & out_lv) | (~oe & ext_en & ext_lv)
               | (~oe & ~ext_en & (pu | (~pd & ~ext_lv)));
endmodule // dpg_board

// >>> verification/dpg_gpio_properties.sv
// Port-level properties of the dual-port GPIO block
module dpg_gpio_properties #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // Write handshakes
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    // Read handshakes and data
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic [31:0]      s_axi_rdata,
    // Pin side
    input wire logic [WIDTH-1:0] porta_pin_oe,
    input wire logic [WIDTH-1:0] porta_pullup_on,
    input wire logic [WIDTH-1:0] portb_pin_oe,
    input wire logic [WIDTH-1:0] portb_pullup_on,
    input wire logic [WIDTH-1:0] portb_pin_in,
    input wire logic [WIDTH-1:0] portb_event_level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address and data of a write taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    a_pullup_gate_a: assert property ((porta_pullup_on & porta_pin_oe) == '0)
        else $error("port A pull-up on an output pin");
    a_pullup_gate_b: assert property ((portb_pullup_on & portb_pin_oe) == '0)
        else $error("port B pull-up on an output pin");
    a_event_gate: assert property ((portb_event_level & ~$past(portb_pin_in, 3)) == '0)
        else $error("event level high without pin high");
    a_reset_inputs: assert property (@(posedge aclk) disable iff (1'h0)
        !aresetn |=> porta_pin_oe == '0 && portb_pin_oe == '0 && !s_axi_bvalid)
        else $error("pins not inputs after reset");
endmodule // dpg_gpio_properties

bind dpg_gpio dpg_gpio_properties #(.WIDTH(WIDTH)) u_props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .porta_pin_oe, .porta_pullup_on, .portb_pin_oe,
    .portb_pullup_on, .portb_pin_in, .portb_event_level);

// >>> verification/dpg_gpio_tb_top.sv
// Self-checking bench for the dual-port GPIO block
module dpg_gpio_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Bus and clock signals
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    // Pin signals and board drive
    logic [7:0] porta_pin_in, porta_pin_out, porta_pin_oe, porta_pullup_on, porta_pulldown_on;
    logic [7:0] portb_pin_in, portb_pin_out, portb_pin_oe, portb_pullup_on, portb_pulldown_on;
    logic [7:0] portb_event_level, ext_lv, ext_en;
    int n_errors, n_compared;
    // Read-write registers: port A data, dir, pull-up, pull-down, then port B
    localparam logic [7:0] RW_IDX [8] = '{dpg_pkg::IDX_PA_DATA, dpg_pkg::IDX_PA_DIR,
        dpg_pkg::IDX_PA_PU, dpg_pkg::IDX_PA_PD, dpg_pkg::IDX_PB_DATA, dpg_pkg::IDX_PB_DIR,
        dpg_pkg::IDX_PB_PU, dpg_pkg::IDX_PB_PD};
    localparam logic [7:0] VALS [4] = '{8'h5A, 8'h0F, 8'hFF, 8'h3C};
    // 125 MHz clock
    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end
    dpg_gpio dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .porta_pin_in, .porta_pin_out, .porta_pin_oe, .porta_pullup_on,
        .porta_pulldown_on, .portb_pin_in, .portb_pin_out, .portb_pin_oe, .portb_pullup_on,
        .portb_pulldown_on, .portb_event_level);
    dpg_board brd_a (.out_lv(porta_pin_out), .oe(porta_pin_oe), .pu(porta_pullup_on),
        .pd(porta_pulldown_on), .ext_lv(ext_lv), .ext_en(ext_en), .pin(porta_pin_in));
    dpg_board brd_b (.out_lv(portb_pin_out), .oe(portb_pin_oe), .pu(portb_pullup_on),
        .pd(portb_pulldown_on), .ext_lv(ext_lv), .ext_en(ext_en), .pin(portb_pin_in));
    // Register index to byte address
    function automatic logic [7:0] ba(input logic [7:0] i);
        return i << 2;
    endfunction
    // Compare a data value
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Compare a response code
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t resp got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bus write; response lands in resp
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    // Bus read; data in rd_d, response in resp
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    // Reset values of the read-write registers and pin controls; the enable register reads zero
    task automatic test_reset;
        foreach (RW_IDX[i]) begin
            rd(ba(RW_IDX[i]));
            chk_val(rd_d, 32'h0);
        end
        rd(ba(dpg_pkg::IDX_PB_IEN));
        chk_val(rd_d, 32'h0);
        chk_val({porta_pin_oe, portb_pin_oe, porta_pin_out, portb_pin_out}, 32'h0);
        chk_val({porta_pullup_on, portb_pullup_on, 16'h0}, 32'h0);
        chk_val({porta_pulldown_on, portb_pulldown_on, 16'h0}, 32'h0);
        $display("test_reset done");
    endtask
    // Program each port, read back, check pin controls and pulls
    task automatic test_regs;
        ext_lv <= 8'hC3;
        ext_en <= 8'h30;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) wr(ba(RW_IDX[4*p+k]), {24'h0, VALS[k]}, 4'hF);
            for (int k = 1; k < 4; k++) begin
                rd(ba(RW_IDX[4*p+k]));
                chk_val(rd_d, {24'h0, VALS[k]});
            end
            rd(ba(RW_IDX[4*p]));
            chk_val(rd_d, 32'hCA);
            chk_val(p ? {portb_pin_oe, portb_pin_out, portb_pullup_on, portb_pulldown_on}
                      : {porta_pin_oe, porta_pin_out, porta_pullup_on, porta_pulldown_on},
                    32'h0F5AF03C);
        end
        $display("test_regs done");
    endtask
    // Input enables gate reads and event levels, all bit groups both ways
    task automatic test_ien;
        logic [31:0] exp_v;
        ext_lv <= 8'hFF;
        ext_en <= 8'hFF;
        wr(ba(dpg_pkg::IDX_PB_DIR), 32'h0, 4'hF);
        wr(ba(dpg_pkg::IDX_PB_PU), 32'h0, 4'hF);
        // Enables still hold their reset value here: all pins pass
        rd(ba(dpg_pkg::IDX_PB_DATA));
        chk_val(rd_d, 32'hFF);
        chk_val({24'h0, portb_event_level}, 32'hFF);
        for (int v = 0; v < 2; v++) begin
            exp_v = v ? 32'hA5 : 32'h5A;
            wr(ba(dpg_pkg::IDX_PB_IEN), exp_v, 4'hF);
            rd(ba(dpg_pkg::IDX_PB_DATA));
            chk_val(rd_d, exp_v);
            chk_val({24'h0, portb_event_level}, exp_v);
            rd(ba(dpg_pkg::IDX_PB_IEN));
            chk_val(rd_d, 32'h0);
        end
        $display("test_ien done");
    endtask
    // Unmapped, unaligned and lane-less accesses
    task automatic test_errors;
        wr(8'h00, 32'hFF, 4'hF);
        chk_resp(resp, dpg_pkg::RESP_SLVERR);
        wr(8'h45, 32'hFF, 4'hF);
        chk_resp(resp, dpg_pkg::RESP_SLVERR);
        rd(8'h7C);
        chk_resp(resp, dpg_pkg::RESP_SLVERR);
        wr(ba(dpg_pkg::IDX_PA_DIR), 32'hFF, 4'h0);
        chk_resp(resp, dpg_pkg::RESP_OKAY);
        rd(ba(dpg_pkg::IDX_PA_DIR));
        chk_val(rd_d, 32'h0F);
        $display("test_errors done");
    endtask
    // Print counts and verdict, then stop
    task automatic give_verdict;
        $display("compared=%0d mismatches=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        aresetn       = 1'h0;
        s_axi_awvalid = 1'h0;
        s_axi_wvalid  = 1'h0;
        s_axi_bready  = 1'h0;
        s_axi_arvalid = 1'h0;
        s_axi_rready  = 1'h0;
        s_axi_awaddr  = 8'h00;
        s_axi_araddr  = 8'h00;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'h0;
        ext_lv        = 8'h00;
        ext_en        = 8'hFF;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        test_reset;
        test_regs;
        test_ien;
        test_errors;
        give_verdict;
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        give_verdict;
    end
endmodule // dpg_gpio_tb_top
